// ==== ars_consts.svh ====
// Constants of the converter reference, input and sequencing block
`ifndef ARS_CONSTS_SVH
`define ARS_CONSTS_SVH

`define ARS_NPIN        8
`define ARS_CHAN_W      3
`define ARS_RES_W       12
`define ARS_SAMPLE_CYC  4'h4
`define ARS_CONV_CYC    4'hc
`define ARS_TOTAL_CYC   5'h10
`define ARS_SAR_MSB     12'h800
`define ARS_DIV_W       7
`define ARS_REF_SUPPLY  4'h0
`define ARS_REF_EXT_LO  4'h1
`define ARS_REF_EXT_HI  4'h4
`define ARS_REF_BG_LO   4'ha
`define ARS_REF_BG_HI   4'hc
`define ARS_SRC_EXT     3'h0
`define ARS_FMT_LEFT    1'h0
`define ARS_NIB_ZERO    4'h0

`endif

// ==== ars_pkg.sv ====
// Types shared by the converter control block and its clock divider
`include "ars_consts.svh"

package ars_pkg;

  typedef enum logic [1:0] {
    ARS_REF_SUPPLY_SRC,
    ARS_REF_EXT_SRC,
    ARS_REF_BG_SRC
  } ars_ref_src_t;

  typedef enum logic [2:0] {
    ARS_IDLE,
    ARS_HELD,
    ARS_SAMPLE,
    ARS_CONVERT,
    ARS_DONE
  } ars_phase_t;

  typedef struct packed {
    logic [`ARS_DIV_W-1:0] cnt;
    logic                  tick;
  } ars_div_t;

  typedef struct packed {
    ars_ref_src_t src;
    logic [2:0]   gain;
    logic         amp_on;
    logic         ext_connect;
    logic         out_drive;
    logic         ext_pin_mode;
  } ars_ref_t;

  typedef struct packed {
    logic [`ARS_NPIN-1:0] analog;
    logic [`ARS_NPIN-1:0] input_dir;
    logic [`ARS_NPIN-1:0] pullup_on;
    logic [`ARS_NPIN-1:0] chan_connect;
  } ars_pins_t;

  typedef struct packed {
    ars_phase_t             phase;
    logic                   start_d;
    logic [3:0]             cnt;
    logic [`ARS_RES_W-1:0]  trial;
    logic                   div_clear;
    logic                   sample_hold;
    logic                   busy;
    logic                   flag;
    logic                   irq;
    logic                   powered;
    logic [7:0]             res_high;
    logic [7:0]             res_low;
    logic                   internal_on;
    logic [2:0]             internal_sel;
    ars_ref_t               ref_cfg;
    ars_pins_t              pins;
  } ars_state_t;

endpackage : ars_pkg

// ==== ars_clk_div.sv ====
// Power-of-two divider making the converter clock tick
`timescale 1ns/1ps
`include "ars_consts.svh"

module ars_clk_div (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       clear,
  input  wire logic [2:0] sel,
  // Converter clock tick
  output logic            tick
);

  ars_pkg::ars_div_t s;
  ars_pkg::ars_div_t next_s;
  logic [`ARS_DIV_W-1:0] mask;

  always_comb begin
    mask = `ARS_DIV_W'((8'h01 << sel) - 8'h01);
    next_s = s;
    // Clearing realigns so the first tick is one full period away
    if (clear) begin
      next_s.cnt  = '0;
      next_s.tick = 1'b0;
    end else begin
      next_s.tick = &(s.cnt | ~mask);
      next_s.cnt  = (s.cnt + 1'b1) & mask;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule : ars_clk_div

// ==== ars_top.sv ====
// Converter reference select, input pin control and conversion sequencer
`timescale 1ns/1ps
`include "ars_consts.svh"

// Function
// - Decode reference code: supply default, external x1..x4, bandgap x2..x4.
// - Amplify external or bandgap reference by one to four; never supply.
// - External and bandgap together: only bandgap reaches the reference.
// - Pin function bit set by software disables the pin's shared functions.
// - Drive the selected reference onto the reference output pin.
// - Only the selected external channel's pin, if its analog enable is set, becomes the channel input, others off.
// - Pull-ups are disconnected while a pin is an analog input.
// - Analog enable overrides the pin's port direction.
// - Conversion is 4 sampling plus 12 converting clocks, 16 total.
// - Internal input source disconnects the external channel input.
// - Busy high during conversion, cleared at end; result then readable.
// - Twelve-bit result, code fff at full scale equal to reference.
// - Result placement in high and low bytes follows the format bit.
// - Power enable low keeps the converter powered down.
// - Start rise resets and clears busy; following fall sets busy.
// - Completion sets the interrupt flag; interrupt raised when enabled.
// - Clock select divides the system clock by 1 up to 128.
module ars_top (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // Converter control
  input  wire logic [2:0]             converter_clock_divider_select,
  input  wire logic                   converter_power_enable,
  input  wire logic                   start,
  input  wire logic                   result_format_select,
  // Input selection
  input  wire logic [2:0]             input_source_select,
  input  wire logic [`ARS_CHAN_W-1:0] external_channel_select,
  input  wire logic [`ARS_NPIN-1:0]   analog_pin_enable_bits,
  input  wire logic [`ARS_NPIN-1:0]   port_direction_input,
  input  wire logic [`ARS_NPIN-1:0]   pullup_select,
  // Reference selection
  input  wire logic [3:0]             reference_source_select,
  input  wire logic                   reference_amplifier_enable,
  input  wire logic                   ext_reference_pin_enable,
  input  wire logic                   reference_output_pin_enable,
  // Interrupt control
  input  wire logic                   global_interrupt_enable,
  input  wire logic                   converter_interrupt_enable,
  input  wire logic                   interrupt_flag_clear,
  // Analog comparator result: input at or above the trial level
  input  wire logic                   compare_above,
  // Reference path
  output ars_pkg::ars_ref_t           reference_amplifier,
  // Pin control
  output ars_pkg::ars_pins_t          pin_control,
  output logic                        internal_source_on,
  output logic [2:0]                  internal_source_sel,
  // Analog core
  output logic                        converter_powered,
  output logic                        sample_hold,
  output logic [`ARS_RES_W-1:0]       trial_code,
  // Status and results
  output logic                        conversion_busy_flag,
  output logic [7:0]                  result_high_byte,
  output logic [7:0]                  result_low_byte,
  output logic                        converter_interrupt_flag,
  output logic                        converter_irq
);

  ars_pkg::ars_state_t s;
  ars_pkg::ars_state_t next_s;
  logic                  tick;
  logic                  start_rise;
  logic                  start_fall;
  logic [`ARS_RES_W-1:0] bit_mask;
  logic [`ARS_RES_W-1:0] kept;
  logic                  done_evt;

  ars_clk_div u_div (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (s.div_clear),
    .sel      (converter_clock_divider_select),
    .tick     (tick)
  );

  always_comb begin
    next_s     = s;
    start_rise = start & ~s.start_d;
    start_fall = ~start & s.start_d;
    bit_mask   = `ARS_SAR_MSB >> s.cnt;
    kept       = compare_above ? s.trial : (s.trial & ~bit_mask);
    done_evt   = 1'b0;
    next_s.start_d   = start;
    next_s.div_clear = 1'b0;
    next_s.powered   = converter_power_enable;

    // Reference source and gain
    next_s.ref_cfg.src  = ars_pkg::ARS_REF_SUPPLY_SRC;
    next_s.ref_cfg.gain = 3'h0;
    if (reference_source_select >= `ARS_REF_BG_LO &&
        reference_source_select <= `ARS_REF_BG_HI) begin
      next_s.ref_cfg.src  = ars_pkg::ARS_REF_BG_SRC;
      next_s.ref_cfg.gain = reference_source_select[2:0];
    end else if (reference_source_select >= `ARS_REF_EXT_LO &&
                 reference_source_select <= `ARS_REF_EXT_HI) begin
      next_s.ref_cfg.src  = ars_pkg::ARS_REF_EXT_SRC;
      next_s.ref_cfg.gain = reference_source_select[2:0];
    end
    // Amplifier runs only when software has enabled it
    next_s.ref_cfg.amp_on = reference_amplifier_enable &&
      next_s.ref_cfg.src != ars_pkg::ARS_REF_SUPPLY_SRC;
    // Bandgap wins; external pin is never tied in alongside it
    next_s.ref_cfg.ext_connect = ext_reference_pin_enable &&
      next_s.ref_cfg.src == ars_pkg::ARS_REF_EXT_SRC;
    next_s.ref_cfg.ext_pin_mode = ext_reference_pin_enable;
    next_s.ref_cfg.out_drive    = reference_output_pin_enable;

    // Pin control
    next_s.pins.analog    = analog_pin_enable_bits;
    next_s.pins.input_dir = port_direction_input |
                            analog_pin_enable_bits;
    next_s.pins.pullup_on = pullup_select &
                            ~analog_pin_enable_bits;
    next_s.internal_on    = input_source_select != `ARS_SRC_EXT;
    next_s.internal_sel   = input_source_select;
    next_s.pins.chan_connect = '0;
    if (input_source_select == `ARS_SRC_EXT) begin
      next_s.pins.chan_connect[external_channel_select] =
        analog_pin_enable_bits[external_channel_select];
    end

    // Sequencer
    if (!converter_power_enable) begin
      next_s.phase       = ars_pkg::ARS_IDLE;
      next_s.busy        = 1'b0;
      next_s.sample_hold = 1'b0;
    end else if (start_rise) begin
      next_s.phase       = ars_pkg::ARS_HELD;
      next_s.busy        = 1'b0;
      next_s.sample_hold = 1'b0;
      next_s.div_clear   = 1'b1;
    end else begin
      case (s.phase)
        ars_pkg::ARS_HELD: begin
          // Divider held cleared while armed, so no stale tick is counted
          next_s.div_clear = 1'b1;
          if (start_fall) begin
            next_s.phase       = ars_pkg::ARS_SAMPLE;
            next_s.busy        = 1'b1;
            next_s.cnt         = '0;
            next_s.div_clear   = 1'b0;
            next_s.sample_hold = 1'b1;
          end
        end
        ars_pkg::ARS_SAMPLE: begin
          if (tick) begin
            if (s.cnt == `ARS_SAMPLE_CYC - 4'h1) begin
              next_s.phase       = ars_pkg::ARS_CONVERT;
              next_s.cnt         = '0;
              next_s.trial       = `ARS_SAR_MSB;
              next_s.sample_hold = 1'b0;
            end else begin
              next_s.cnt = s.cnt + 4'h1;
            end
          end
        end
        ars_pkg::ARS_CONVERT: begin
          if (tick) begin
            if (s.cnt == `ARS_CONV_CYC - 4'h1) begin
              // Full-scale input keeps every bit, giving code fff
              next_s.phase = ars_pkg::ARS_DONE;
              next_s.trial = kept;
              if (result_format_select == `ARS_FMT_LEFT) begin
                next_s.res_high = kept[11:4];
                next_s.res_low  = {kept[3:0], `ARS_NIB_ZERO};
              end else begin
                next_s.res_high = {`ARS_NIB_ZERO, kept[11:8]};
                next_s.res_low  = kept[7:0];
              end
            end else begin
              next_s.trial = kept | (bit_mask >> 1);
              next_s.cnt   = s.cnt + 4'h1;
            end
          end
        end
        ars_pkg::ARS_DONE: begin
          next_s.phase = ars_pkg::ARS_IDLE;
          next_s.busy  = 1'b0;
          done_evt     = 1'b1;
        end
        default: begin
          next_s.phase = ars_pkg::ARS_IDLE;
        end
      endcase
    end

    // A completion in the clearing cycle still leaves the flag set
    next_s.flag = (s.flag & ~interrupt_flag_clear) | done_evt;
    next_s.irq  = next_s.flag & global_interrupt_enable &
                  converter_interrupt_enable;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reference_amplifier      = s.ref_cfg;
  assign pin_control              = s.pins;
  assign internal_source_on       = s.internal_on;
  assign internal_source_sel      = s.internal_sel;
  assign converter_powered        = s.powered;
  assign sample_hold              = s.sample_hold;
  assign trial_code               = s.trial;
  assign conversion_busy_flag     = s.busy;
  assign result_high_byte         = s.res_high;
  assign result_low_byte          = s.res_low;
  assign converter_interrupt_flag = s.flag;
  assign converter_irq            = s.irq;

  // Checking
  logic [4:0] busy_ticks;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_ticks <= '0;
    end else if (s.phase == ars_pkg::ARS_HELD) begin
      busy_ticks <= '0;
    end else if (tick && (s.phase == ars_pkg::ARS_SAMPLE ||
                          s.phase == ars_pkg::ARS_CONVERT)) begin
      busy_ticks <= busy_ticks + 5'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence seq_armed;
    converter_power_enable && s.phase == ars_pkg::ARS_HELD;
  endsequence

  sequence seq_released;
    converter_power_enable && !start;
  endsequence

  AST_BUSY_ON_FALL: assert property (
    seq_armed ##0 seq_released |=> conversion_busy_flag && sample_hold)
    else $error("busy not set after start release");

  AST_RISE_CLEARS: assert property (
    $rose(start) |=> !conversion_busy_flag)
    else $error("start rise did not clear busy");

  AST_CONV_LEN: assert property (
    s.phase == ars_pkg::ARS_DONE |-> busy_ticks == `ARS_TOTAL_CYC)
    else $error("conversion did not take sixteen converter clocks");

  AST_DONE_FLAG: assert property (
    s.phase == ars_pkg::ARS_DONE |=> converter_interrupt_flag
      ##0 !conversion_busy_flag)
    else $error("completion did not set flag and clear busy");

  AST_RESULT_HOLD: assert property (
    !$stable(result_low_byte) || !$stable(result_high_byte)
      |-> $past(s.phase) == ars_pkg::ARS_CONVERT && conversion_busy_flag)
    else $error("result changed outside completion");

  AST_BG_ONLY: assert property (
    reference_amplifier.src == ars_pkg::ARS_REF_BG_SRC
      |-> !reference_amplifier.ext_connect)
    else $error("external reference tied in with bandgap");

  AST_SUPPLY_UNAMP: assert property (
    reference_amplifier.src == ars_pkg::ARS_REF_SUPPLY_SRC
      |-> reference_amplifier.gain == 3'h0 && !reference_amplifier.amp_on)
    else $error("supply reference amplified");

  AST_PULLUP_OFF: assert property (
    (pin_control.analog & pin_control.pullup_on) == '0)
    else $error("pull-up left on an analog pin");

  AST_DIR_OVERRIDE: assert property (
    (pin_control.analog & ~pin_control.input_dir) == '0)
    else $error("analog pin not forced to input");

  AST_INTERNAL_DISC: assert property (
    internal_source_on |-> pin_control.chan_connect == '0)
    else $error("external channel connected with internal source");

  AST_POWER_DOWN: assert property (
    !converter_power_enable |=> !conversion_busy_flag && !converter_powered)
    else $error("converter active while powered down");

  AST_IRQ_GATE: assert property (
    converter_irq |-> converter_interrupt_flag && $past(
      global_interrupt_enable && converter_interrupt_enable))
    else $error("interrupt without flag or enables");

endmodule : ars_top

// ==== ars_analog_model.sv ====
// Behavioural analog front end: held input level and comparator
`timescale 1ns/1ps

module ars_analog_model (
  // Clock
  input  wire logic        core_clk,
  // Converter side
  input  wire logic        powered,
  input  wire logic        sample_hold,
  input  wire logic [11:0] trial_code,
  // Level applied on the selected pin
  input  wire logic [11:0] vin,
  // Comparator decision
  output logic             compare_above
);
  logic [11:0] held;
  logic        junk;

  initial begin
    held = 12'h000;
    junk = 1'b0;
  end

  // Level frozen once sampling ends, like a hold capacitor
  always @(posedge core_clk) begin
    if (sample_hold) begin
      held <= vin;
    end
    junk <= ~junk;
  end

  // Unpowered comparator gives a changing, untrustworthy answer
  assign compare_above = powered ? (held >= trial_code) : junk;
endmodule : ars_analog_model

// ==== ars_top_test.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module ars_top_test;
  logic               core_clk = 1'b0;
  logic               rst      = 1'b1;
  logic [2:0]         div_sel  = 3'h0;
  logic               pwr      = 1'b0;
  logic               start    = 1'b0;
  logic               fmt      = 1'b0;
  logic [2:0]         src_sel  = 3'h0;
  logic [2:0]         chan     = 3'h0;
  logic [7:0]         pin_en   = 8'h00;
  logic [7:0]         dir      = 8'h00;
  logic [7:0]         pu       = 8'h00;
  logic [3:0]         ref_sel  = 4'h0;
  logic               amp_en   = 1'b0;
  logic               vref_in  = 1'b0;
  logic               vref_out = 1'b0;
  logic               gie      = 1'b0;
  logic               cie      = 1'b0;
  logic               flag_clr = 1'b0;
  logic [11:0]        vin      = 12'h000;
  logic               above;
  ars_pkg::ars_ref_t  refo;
  ars_pkg::ars_pins_t pins;
  logic               int_on;
  logic [2:0]         int_sel;
  logic               powered;
  logic               sh;
  logic [11:0]        trial;
  logic               busy;
  logic [7:0]         hi;
  logic [7:0]         lo;
  logic               flag;
  logic               irq;
  int                 n_errors   = 0;
  int                 n_compared = 0;
  int                 len [4];

  always #12.5 core_clk = ~core_clk;

  ars_top ars_top_i (
    .core_clk(core_clk), .rst(rst),
    .converter_clock_divider_select(div_sel),
    .converter_power_enable(pwr), .start(start),
    .result_format_select(fmt), .input_source_select(src_sel),
    .external_channel_select(chan), .analog_pin_enable_bits(pin_en),
    .port_direction_input(dir), .pullup_select(pu),
    .reference_source_select(ref_sel),
    .reference_amplifier_enable(amp_en),
    .ext_reference_pin_enable(vref_in),
    .reference_output_pin_enable(vref_out),
    .global_interrupt_enable(gie), .converter_interrupt_enable(cie),
    .interrupt_flag_clear(flag_clr), .compare_above(above),
    .reference_amplifier(refo), .pin_control(pins),
    .internal_source_on(int_on), .internal_source_sel(int_sel),
    .converter_powered(powered), .sample_hold(sh), .trial_code(trial),
    .conversion_busy_flag(busy), .result_high_byte(hi),
    .result_low_byte(lo), .converter_interrupt_flag(flag),
    .converter_irq(irq));

  ars_analog_model ars_analog_model_i (
    .core_clk(core_clk), .powered(powered), .sample_hold(sh),
    .trial_code(trial), .vin(vin), .compare_above(above));

  function automatic logic [15:0] exp_res(logic [11:0] v, logic f);
    return f ? {4'h0, v} : {v, 4'h0};
  endfunction : exp_res

  function automatic ars_pkg::ars_pins_t exp_pins(logic [7:0] e, d, p,
                                                  logic [2:0] s, c);
    ars_pkg::ars_pins_t r;
    r.analog       = e;
    r.input_dir    = d | e;
    r.pullup_on    = p & ~e;
    r.chan_connect = (s == 3'h0 && e[c]) ? 8'h01 << c : 8'h00;
    return r;
  endfunction : exp_pins

  function automatic ars_pkg::ars_ref_src_t exp_src(logic [3:0] c);
    if (c >= 4'h1 && c <= 4'h4)
      return ars_pkg::ARS_REF_EXT_SRC;
    if (c >= 4'ha && c <= 4'hc)
      return ars_pkg::ARS_REF_BG_SRC;
    return ars_pkg::ARS_REF_SUPPLY_SRC;
  endfunction : exp_src

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // Start pulse, then bounded wait on busy; length of busy returned
  task automatic convert(input logic [11:0] v, input logic f,
                         input logic [2:0] d, output int n);
    div_sel  = d;
    vin      = v;
    fmt      = f;
    flag_clr = 1'b1;
    step(1);
    flag_clr = 1'b0;
    start    = 1'b1;
    step(1);
    start    = 1'b0;
    n        = 0;
    for (int i = 0; i < 8 && busy !== 1'b1; i++) step(1);
    while (busy === 1'b1 && n < 5000) begin
      step(1);
      n++;
    end
    `CHK(busy, 1'b0);
    `CHK({hi, lo}, exp_res(v, f));
    `CHK(trial, v);
    `CHK(flag, 1'b1);
    step(1);
    `CHK(irq, gie & cie);
  endtask : convert

  initial begin
    #(25 * 40000);
    n_errors++;
    end_sim;
  end

  initial begin
    void'($urandom(32'h10545efc));
    step(2);
    rst = 1'b0;
    `CHK({busy, flag, hi, lo, irq}, 19'h00000);
    pwr = 1'b1;
    // Every reference code, with and without the external pin function
    for (int i = 0; i < 32; i++) begin
      ref_sel  = i[3:0];
      vref_in  = i[4];
      vref_out = ~i[4];
      amp_en   = exp_src(i[3:0]) != ars_pkg::ARS_REF_SUPPLY_SRC;
      step(2);
      `CHK(refo.src, exp_src(i[3:0]));
      `CHK(refo.gain, amp_en ? i[2:0] : 3'h0);
      `CHK(refo.amp_on, amp_en);
      `CHK(refo.ext_pin_mode, vref_in);
      `CHK(refo.out_drive, vref_out);
      if (exp_src(i[3:0]) == ars_pkg::ARS_REF_BG_SRC) begin
        `CHK(refo.ext_connect, 1'b0);
      end else if (exp_src(i[3:0]) == ars_pkg::ARS_REF_EXT_SRC) begin
        `CHK(refo.ext_connect, vref_in);
      end
    end
    $display("reference selection test done");
    for (int i = 0; i < 40; i++) begin
      pin_en  = 8'($urandom);
      dir     = 8'($urandom);
      pu      = 8'($urandom);
      src_sel = (i % 3 == 0) ? 3'($urandom) : 3'h0;
      chan    = 3'($urandom);
      step(2);
      `CHK(pins, exp_pins(pin_en, dir, pu, src_sel, chan));
      `CHK({int_on, int_sel}, {src_sel != 3'h0, src_sel});
    end
    $display("pin configuration test done");
    // External source, pin 0 enabled and channel 0 chosen in the same step
    src_sel = 3'h0;
    pin_en  = 8'h01;
    chan    = 3'h0;
    for (int d = 0; d < 4; d++) begin
      {gie, cie} = d[1:0];
      convert(d == 0 ? 12'hfff : d == 1 ? 12'h000 : 12'($urandom),
              d[0], d[2:0], len[d]);
    end
    `CHK(len[1] - len[0], 16);
    `CHK(len[3] - len[0], 112);
    for (int i = 0; i < 6; i++) begin
      convert(12'($urandom), 1'($urandom), 3'h0, len[0]);
    end
    $display("conversion test done");
    // A new rise in mid-conversion aborts and keeps old results
    flag_clr = 1'b1;
    step(1);
    flag_clr = 1'b0;
    {gie, cie} = 2'h3;
    convert(12'h5a3, 1'b1, 3'h2, len[0]);
    flag_clr = 1'b1;
    vin      = 12'ha5c;
    step(1);
    flag_clr = 1'b0;
    start    = 1'b1;
    step(1);
    start    = 1'b0;
    step(12);
    `CHK(busy, 1'b1);
    start = 1'b1;
    step(2);
    `CHK({busy, flag, hi, lo}, {2'h0, exp_res(12'h5a3, 1'b1)});
    start = 1'b0;
    step(2);
    `CHK(busy, 1'b1);
    for (int i = 0; i < 300 && busy === 1'b1; i++) step(1);
    `CHK({hi, lo}, exp_res(12'ha5c, 1'b1));
    $display("abort test done");
    // Power off: start ignored, converter idle
    pwr = 1'b0;
    step(2);
    `CHK(powered, 1'b0);
    start = 1'b1;
    step(1);
    start = 1'b0;
    step(4);
    `CHK(busy, 1'b0);
    $display("power test done");
    end_sim;
  end
endmodule : ars_top_test
